// *** rtl/gate_drive_overcurrent_sequencer.sv ***
`timescale 1ns/1ps
// Notes on behaviour
// [R1] An overcurrent event is flagged whenever the sense comparator reports the 20 mV trip.
// [R2] During overcurrent the high side turns off at once and the low side comes on after any dead time, then is held until the next cycle starts.
// [R3] Seven consecutive switching cycles with overcurrent trigger the latched protection.
// [R4] Once protection triggers, both gate drives are forced off and held off by a latch.
// [R5] The protection latch clears only on a reset or by cycling the enable input low.
// [R6] With no sync input the switching cycle free-runs at 200 kHz.
// [R7] A falling edge on the sync input starts a new cycle and so the high-side turn-on.
// [R8] After high-side turn-off the low side waits until the switch node is below about 2 V.
// [R9] After low-side turn-off the high side waits until the low gate is below about 1 V.
// [R10] If the switch node never falls, a watchdog timeout turns the low side on anyway.
// [R11] Holding the frequency-set pin low disables the block with both drives off.
// [R12] The consecutive overcurrent count returns to zero after any cycle without overcurrent.
// [R13] The high side turns on at cycle start and off when the PWM comparator ends the duty.
module gate_drive_overcurrent_sequencer (
    // Clock and reset
    input  wire logic                  clock,
    input  wire logic                  arst_n,
    // Comparator, sync and control pins
    input  wire gate_drive_pkg::pins_type pins,
    // Gate drives
    output logic                       high_side_switch,
    output logic                       low_side_switch,
    // Status
    output logic                       overcurrent_event,
    output logic                       protection_latched
);

    gate_drive_pkg::pins_type      p;
    gate_drive_pkg::seq_state_type s_r;
    gate_drive_pkg::seq_state_type s_nxt;
    logic                          run;
    logic                          sync_fall;
    logic                          start;

    pin_synchronizer #(
        .WIDTH ($bits(gate_drive_pkg::pins_type))
    ) u_pins (
        .clock    (clock),
        .arst_n   (arst_n),
        .raw      (pins),
        .filtered (p)
    );

    assign run       = p.enable && p.frequency_set_pin;                 // see [R11]
    assign sync_fall = s_r.sync_d && !p.sync_in;
    assign start     = (s_r.cycle == gate_drive_pkg::PERIOD_LAST) || sync_fall; // see [R6] [R7]

    always_comb begin
        s_nxt         = s_r;
        s_nxt.sync_d  = p.sync_in;
        s_nxt.oc_flag = p.oc_trip;                                      // see [R1]
        s_nxt.cycle   = start ? gate_drive_pkg::CYCLE_RESET : 9'(s_r.cycle + 9'h001);
        if (!p.enable) begin
            s_nxt.latched = 1'b0;                                       // see [R5]
        end
        if (!run || s_r.latched) begin
            // Disabled or protected: nothing switches
            s_nxt.phase    = gate_drive_pkg::ST_OFF;                    // see [R4] [R11]
            s_nxt.high     = 1'b0;
            s_nxt.low      = 1'b0;
            s_nxt.oc_count = gate_drive_pkg::OC_COUNT_RESET;
            s_nxt.oc_seen  = 1'b0;
        end else if (start) begin
            s_nxt.oc_seen = p.oc_trip;
            if (s_r.oc_seen) begin
                s_nxt.oc_count = 3'(s_r.oc_count + 3'h1);               // see [R3]
            end else begin
                s_nxt.oc_count = gate_drive_pkg::OC_COUNT_RESET;        // see [R12]
            end
            if (s_r.oc_seen && s_nxt.oc_count == gate_drive_pkg::OC_LIMIT) begin
                s_nxt.latched = 1'b1;                                   // see [R3] [R4]
                s_nxt.phase   = gate_drive_pkg::ST_OFF;
                s_nxt.high    = 1'b0;
                s_nxt.low     = 1'b0;
            end else if (s_r.phase == gate_drive_pkg::ST_WAIT_SWITCH) begin
                // Dead time still running: skipping it would bypass the node check
                s_nxt.phase = gate_drive_pkg::ST_WAIT_SWITCH;               // see [R8]
            end else if (s_r.high) begin
                // Full duty at cycle end still needs dead time before the low side
                s_nxt.high     = 1'b0;
                s_nxt.watchdog = gate_drive_pkg::WATCHDOG_RESET;
                s_nxt.phase    = gate_drive_pkg::ST_WAIT_SWITCH;
            end else if (p.oc_trip) begin
                s_nxt.low   = 1'b1;                                     // see [R2]
                s_nxt.phase = gate_drive_pkg::ST_LOW;
            end else begin
                s_nxt.low   = 1'b0;
                s_nxt.phase = gate_drive_pkg::ST_WAIT_LOW_GATE;         // see [R13]
            end
        end else begin
            if (p.oc_trip) begin
                s_nxt.oc_seen = 1'b1;
            end
            case (s_r.phase)
                gate_drive_pkg::ST_WAIT_LOW_GATE: begin
                    if (p.oc_trip) begin
                        s_nxt.low   = 1'b1;                             // see [R2]
                        s_nxt.phase = gate_drive_pkg::ST_LOW;
                    end else if (p.low_gate_low) begin
                        s_nxt.high  = 1'b1;                             // see [R9] [R13]
                        s_nxt.phase = gate_drive_pkg::ST_HIGH;
                    end
                end
                gate_drive_pkg::ST_HIGH: begin
                    if (p.oc_trip || p.pwm_end) begin
                        s_nxt.high     = 1'b0;                          // see [R2] [R13]
                        s_nxt.watchdog = gate_drive_pkg::WATCHDOG_RESET;
                        s_nxt.phase    = gate_drive_pkg::ST_WAIT_SWITCH;
                    end
                end
                gate_drive_pkg::ST_WAIT_SWITCH: begin
                    if (p.switch_node_low ||
                        s_r.watchdog == gate_drive_pkg::WATCHDOG_LAST) begin
                        s_nxt.low   = 1'b1;                             // see [R8] [R10]
                        s_nxt.phase = gate_drive_pkg::ST_LOW;
                    end else begin
                        s_nxt.watchdog = 8'(s_r.watchdog + 8'h01);
                    end
                end
                default: begin
                    // Low side and off phases leave only at cycle start
                    s_nxt.phase = s_r.phase;                            // see [R2]
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            s_r          <= '0;
            s_r.phase    <= gate_drive_pkg::ST_OFF;
            s_r.cycle    <= gate_drive_pkg::CYCLE_RESET;
            s_r.watchdog <= gate_drive_pkg::WATCHDOG_RESET;
            s_r.oc_count <= gate_drive_pkg::OC_COUNT_RESET;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign high_side_switch   = s_r.high;
    assign low_side_switch    = s_r.low;
    assign overcurrent_event  = s_r.oc_flag;
    assign protection_latched = s_r.latched;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!arst_n);

    a_oc_flag_follow: assert property (p.oc_trip |=> overcurrent_event) // see [R1]
        else $error("overcurrent flag missed a trip");
    a_oc_high_drop: assert property (
        run && !s_r.latched && !start && s_r.phase == gate_drive_pkg::ST_HIGH && p.oc_trip
        |=> !high_side_switch) // see [R2]
        else $error("high side stayed on during overcurrent");
    a_low_hold_cycle: assert property (
        run && !s_r.latched && !start && s_r.phase == gate_drive_pkg::ST_LOW
        |=> low_side_switch) // see [R2]
        else $error("low side released before cycle start");
    a_seven_latch: assert property (
        run && !s_r.latched && start && s_r.oc_seen && s_r.oc_count == 3'h6
        |=> protection_latched ##1 !high_side_switch && !low_side_switch) // see [R3]
        else $error("seventh overcurrent cycle did not latch");
    a_latch_off: assert property (
        protection_latched |-> !high_side_switch && !low_side_switch) // see [R4]
        else $error("drive active while latched");
    a_latch_hold: assert property (
        protection_latched && p.enable |=> protection_latched) // see [R5]
        else $error("latch cleared without enable cycle");
    a_period_wrap: assert property (
        s_r.cycle == gate_drive_pkg::PERIOD_LAST |=> s_r.cycle == gate_drive_pkg::CYCLE_RESET)
        // see [R6]
        else $error("switching period not 500 cycles");
    a_sync_restart: assert property (sync_fall |=> s_r.cycle == 9'h000) // see [R7]
        else $error("sync edge did not restart cycle");
    a_dead_low: assert property (
        $rose(low_side_switch) && $past(s_r.phase) == gate_drive_pkg::ST_WAIT_SWITCH
        |-> $past(p.switch_node_low) || $past(s_r.watchdog) == gate_drive_pkg::WATCHDOG_LAST)
        // see [R8]
        else $error("low side on before switch node fell");
    a_dead_high: assert property ($rose(high_side_switch) |-> $past(p.low_gate_low)) // see [R9]
        else $error("high side on with low gate still high");
    a_watchdog_fire: assert property (
        run && !s_r.latched && !start && s_r.phase == gate_drive_pkg::ST_WAIT_SWITCH
        && s_r.watchdog == gate_drive_pkg::WATCHDOG_LAST |=> low_side_switch) // see [R10]
        else $error("watchdog did not force low side");
    a_disable_off: assert property (!run |=> !high_side_switch && !low_side_switch) // see [R11]
        else $error("drive active while disabled");
    a_count_clear: assert property (
        run && !s_r.latched && start && !s_r.oc_seen |=> s_r.oc_count == 3'h0) // see [R12]
        else $error("overcurrent count not cleared");
    a_pwm_end_off: assert property (
        run && !s_r.latched && !start && s_r.phase == gate_drive_pkg::ST_HIGH && p.pwm_end
        |=> !high_side_switch) // see [R13]
        else $error("high side stayed on after duty end");

    c_normal_cycle: cover property ($rose(high_side_switch) ##[1:500] $rose(low_side_switch));
    c_watchdog: cover property (
        s_r.phase == gate_drive_pkg::ST_WAIT_SWITCH
        && s_r.watchdog == gate_drive_pkg::WATCHDOG_LAST);
    c_latch: cover property ($rose(protection_latched));
    c_sync: cover property (sync_fall && run);

endmodule // gate_drive_overcurrent_sequencer

// *** rtl/gate_drive_pkg.sv ***
package gate_drive_pkg;

    // Timing
    localparam int unsigned CLOCK_PERIOD_NS   = 10;
    localparam int unsigned SWITCH_FREQ_KHZ   = 200;
    localparam int unsigned PERIOD_CYCLES     = 1000000 / (SWITCH_FREQ_KHZ * CLOCK_PERIOD_NS);
    localparam int unsigned WATCHDOG_NS       = 250;
    localparam int unsigned WATCHDOG_CYCLES   = WATCHDOG_NS / CLOCK_PERIOD_NS;
    localparam logic [8:0]  PERIOD_LAST       = 9'(PERIOD_CYCLES - 1);
    localparam logic [7:0]  WATCHDOG_LAST     = 8'(WATCHDOG_CYCLES - 1);

    // Overcurrent
    localparam logic [2:0]  OC_LIMIT          = 3'h7;

    // Reset values
    localparam logic [8:0]  CYCLE_RESET       = 9'h000;
    localparam logic [7:0]  WATCHDOG_RESET    = 8'h00;
    localparam logic [2:0]  OC_COUNT_RESET    = 3'h0;

    typedef enum logic [2:0] {
        ST_OFF,
        ST_WAIT_LOW_GATE,
        ST_HIGH,
        ST_WAIT_SWITCH,
        ST_LOW
    } phase_type;

    // Comparator and control pins, all from outside the clock domain
    typedef struct packed {
        logic oc_trip;
        logic switch_node_low;
        logic low_gate_low;
        logic pwm_end;
        logic sync_in;
        logic frequency_set_pin;
        logic enable;
    } pins_type;

    typedef struct packed {
        phase_type  phase;
        logic [8:0] cycle;
        logic [7:0] watchdog;
        logic [2:0] oc_count;
        logic       oc_seen;
        logic       oc_flag;
        logic       latched;
        logic       high;
        logic       low;
        logic       sync_d;
    } seq_state_type;

endpackage

// *** rtl/pin_synchronizer.sv ***
`timescale 1ns/1ps
module pin_synchronizer #(
    parameter int unsigned WIDTH = 7
) (
    // Clock and reset
    input  wire logic             clock,
    input  wire logic             arst_n,
    // Raw pins and filtered result
    input  wire logic [WIDTH-1:0] raw,
    output logic      [WIDTH-1:0] filtered
);

    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] out;
    } sync_state_type;

    sync_state_type s_r;
    sync_state_type s_nxt;

    // A bit changes only once the second and third stages agree
    always_comb begin
        s_nxt     = s_r;
        s_nxt.s1  = raw;
        s_nxt.s2  = s_r.s1;
        s_nxt.s3  = s_r.s2;
        s_nxt.out = (s_r.s2 & s_r.s3) | (s_r.out & (s_r.s2 | s_r.s3));
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign filtered = s_r.out;

endmodule // pin_synchronizer

// *** dv/half_bridge_model.sv ***
`timescale 1ns/1ps
module half_bridge_model (
    // Clock
    input  wire logic clock,
    // Gate drives and fault control
    input  wire logic high_side_switch,
    input  wire logic low_side_switch,
    input  wire logic node_stuck,
    // Comparator levels
    output logic      switch_node_low,
    output logic      low_gate_low
);
    logic [2:0] node_r;
    logic [2:0] gate_r;

    // Three cycles of slew, so the block has a real dead time to wait out
    always_ff @(posedge clock) begin
        node_r <= {node_r[1:0], ~high_side_switch & ~node_stuck};
        gate_r <= {gate_r[1:0], ~low_side_switch};
    end

    // Negative inductor current keeps the node up
    assign switch_node_low = node_r[2] & ~high_side_switch & ~node_stuck;
    assign low_gate_low    = gate_r[2] & ~low_side_switch;
endmodule // half_bridge_model

// *** dv/gate_drive_overcurrent_sequencer_bench.sv ***
`timescale 1ns/1ps
module gate_drive_overcurrent_sequencer_bench;
    logic                     clock   = 1'b0;
    logic                     arst_n  = 1'b0;
    logic                     oc      = 1'b0;
    logic                     pwm_end = 1'b0;
    logic                     sync    = 1'b1;
    logic                     fset    = 1'b1;
    logic                     en      = 1'b1;
    logic                     stuck   = 1'b0;
    logic                     sn_low;
    logic                     lg_low;
    logic                     high;
    logic                     low;
    logic                     oc_event;
    logic                     latched;
    gate_drive_pkg::pins_type pins;
    int                       err_count   = 0;
    int                       checks_done = 0;
    int                       cyc         = 0;
    int                       duty        = 0;

    assign pins = {oc, sn_low, lg_low, pwm_end, sync, fset, en};

    gate_drive_overcurrent_sequencer gate_drive_overcurrent_sequencer_inst (
        .clock(clock), .arst_n(arst_n), .pins(pins),
        .high_side_switch(high), .low_side_switch(low),
        .overcurrent_event(oc_event), .protection_latched(latched));

    half_bridge_model half_bridge_model_inst (
        .clock(clock), .high_side_switch(high), .low_side_switch(low),
        .node_stuck(stuck), .switch_node_low(sn_low), .low_gate_low(lg_low));

    initial begin
        forever #5 clock = ~clock;
    end

    // Stand-in for the ramp comparator: duty ends 100 cycles after turn-on
    always @(posedge clock) begin
        #2;
        duty = high ? duty + 1 : 0;
        pwm_end = duty >= 100;
        cyc = cyc + 1;
        check_bit(high & low, 1'b0, "both drives on");
        if (cyc > 40000) begin
            err_count++;
            final_report();
        end
    end

    task automatic tick(input int n);
        repeat (n) begin
            @(posedge clock);
            #2;
        end
    endtask

    function automatic logic pick(input int sel);
        case (sel)
            0: return high;
            1: return low;
            2: return oc_event;
            default: return latched;
        endcase
    endfunction

    task automatic wait_for(input int sel, input logic lvl, input int limit, output int n);
        n = 0;
        do begin
            tick(1);
            n++;
        end while (pick(sel) !== lvl && n < limit);
    endtask

    task automatic check_bit(input logic got, input logic exp, input string msg);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask

    task automatic check_range(input int got, input int lo, input int hi, input string msg);
        checks_done++;
        if (got < lo || got > hi) begin
            err_count++;
            $display("wrong value at %0t: %s, %0d cycles", $time, msg, got);
        end
    endtask

    task automatic t_normal();
        int a, b, c;
        // First turn-on after reset has no dead time to wait out, so measure the next one
        wait_for(0, 1'b1, 1100, a);
        wait_for(0, 1'b0, 200, a);
        wait_for(0, 1'b1, 600, a);
        wait_for(0, 1'b0, 200, a);
        check_range(a, 100, 110, "duty end");
        wait_for(1, 1'b1, 100, b);
        check_range(b, 4, 20, "dead time to low");
        wait_for(0, 1'b1, 600, c);
        check_bit(low, 1'b0, "low on at high turn-on");
        check_range(a + b + c, 500, 500, "switching period");
        $display("test normal done");
    endtask

    task automatic t_sync();
        int n;
        wait_for(0, 1'b1, 600, n);
        tick(200);
        sync = 1'b0;
        wait_for(0, 1'b1, 100, n);
        check_range(n, 5, 40, "turn-on after sync fall");
        sync = 1'b1;
        $display("test sync done");
    endtask

    task automatic t_watchdog();
        int n;
        stuck = 1'b1;
        wait_for(0, 1'b1, 600, n);
        wait_for(0, 1'b0, 200, n);
        wait_for(1, 1'b1, 100, n);
        check_range(n, 24, 30, "forced low turn-on");
        stuck = 1'b0;
        $display("test watchdog done");
    endtask

    task automatic t_disable();
        int n;
        fset = 1'b0;
        tick(10);
        check_bit(high | low, 1'b0, "drives on while disabled");
        tick(600);
        check_bit(high | low, 1'b0, "drives on while disabled");
        fset = 1'b1;
        wait_for(0, 1'b1, 1100, n);
        check_bit(high, 1'b1, "no restart after disable");
        $display("test disable done");
    endtask

    // Six overcurrent cycles, one clean, six more: the count must restart
    task automatic t_oc_clear();
        int n;
        wait_for(0, 1'b1, 600, n);
        oc = 1'b1;
        tick(2800);
        oc = 1'b0;
        tick(700);
        oc = 1'b1;
        tick(2800);
        oc = 1'b0;
        tick(600);
        check_bit(latched, 1'b0, "count kept over a clean cycle");
        $display("test oc clear done");
    endtask

    task automatic t_oc_latch();
        int n, t0;
        wait_for(0, 1'b1, 600, n);
        oc = 1'b1;
        t0 = cyc;
        wait_for(2, 1'b1, 10, n);
        check_range(n, 1, 8, "overcurrent flag");
        wait_for(1, 1'b1, 30, n);
        check_range(n, 1, 29, "low on in overcurrent");
        tick(600);
        check_bit(low, 1'b1, "low dropped across cycle start");
        wait_for(3, 1'b1, 3000, n);
        check_range(cyc - t0, 2990, 3510, "protection after seven cycles");
        tick(2);
        check_bit(high | low, 1'b0, "drives on when latched");
        oc = 1'b0;
        tick(600);
        check_bit(latched, 1'b1, "latch let go");
        check_bit(high | low, 1'b0, "drives on when latched");
        en = 1'b0;
        wait_for(3, 1'b0, 10, n);
        check_range(n, 1, 8, "latch kept after enable cycle");
        en = 1'b1;
        $display("test oc latch done");
    endtask

    task automatic final_report();
        $display("checks %0d, mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        tick(16);
        arst_n = 1'b1;
        t_normal();
        t_sync();
        t_watchdog();
        t_disable();
        t_oc_clear();
        t_oc_latch();
        final_report();
    end
endmodule // gate_drive_overcurrent_sequencer_bench
